// *** tmx_timer.sv ***
`default_nettype none
module tmx_timer #(
    parameter int CNT_W = 8,
    parameter int DIV_W = 6
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [7:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    output logic [31:0] dat_o,
    output logic ack_o,
    input wire logic meas_i,
    output logic pulse_o,
    output logic run_o,
    output logic irq_o
);
    // Byte-wide bus data leaves no room for wider counters
    if (CNT_W < 2 || CNT_W > 8) begin : g_chk
        $error("tmx_timer: CNT_W must be 2..8");
    end

    // Mode register fields
    tmx_pkg::tmx_mode_t mode_r, mode_nxt; // Operating mode select
    logic extra_r, extra_nxt; // Additional mode bit
    logic pol_r, pol_nxt; // Measurement edge polarity
    logic cmd_r, cmd_nxt; // Start/stop command latch
    tmx_pkg::tmx_run_t run_r, run_nxt; // Running state shown on run bit
    logic edge_flag_r, edge_flag_nxt; // Active edge flag
    logic uf_flag_r, uf_flag_nxt; // Underflow flag
    // Counting state
    logic [CNT_W-1:0] pre_rld_r, pre_rld_nxt; // Prescaler reload
    logic [CNT_W-1:0] pre_cnt_r, pre_cnt_nxt; // Prescaler count
    logic [CNT_W-1:0] cnt_rld_r, cnt_rld_nxt; // Counter reload
    logic [CNT_W-1:0] cnt_r, cnt_nxt; // Counter
    logic [CNT_W-1:0] cap_r, cap_nxt; // Value caught at measured edge
    logic pend_r, pend_nxt; // Edge seen, waiting for prescaler underflow
    logic pulse_r, pulse_nxt; // Pulse output level
    logic [1:0] src_r, src_nxt; // Count source select
    logic [tmx_pkg::IRQ_N-1:0] ist_r, ist_nxt; // Sticky interrupt status
    logic [tmx_pkg::IRQ_N-1:0] imsk_r, imsk_nxt; // Interrupt mask
    // Bus slave state
    logic ack_r, ack_nxt;
    logic [31:0] rdat_r, rdat_nxt;
    // Internal strobes
    logic src_tick; // Count source tick from divider
    logic edge_evt; // Measurement edge pulse
    logic tick_c; // Tick feeding run flop and counters
    logic count_en; // Counting tick while running
    logic pre_uf; // Prescaler underflow
    logic uf_evt; // Counter underflow
    logic edge_set; // Edge flag set event
    logic ppm; // Pulse period measurement mode
    logic acc; // Access completes at this edge
    logic wr_mode, wr_pre, wr_cnt, wr_src, wr_msk, rd_ist;
    logic [7:0] wdb; // Write data byte
    logic [7:0] rmux; // Read multiplexer
    logic [tmx_pkg::IRQ_N-1:0] ev; // Events into status bits

    // Count source divider
    tmx_src_tick #(.DIV_W(DIV_W)) u_src (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .sel_i(src_r),
        .tick_o(src_tick)
    );

    // Edge detector on the measurement pin
    tmx_edge_det u_edge (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .sig_i(meas_i),
        .pol_i(pol_r),
        .edge_o(edge_evt)
    );

    // Decode; writes land on the edge where the master sees ack
    always_comb begin
        acc = cyc_i & stb_i & ack_r;
        wdb = dat_i[7:0];
        wr_mode = acc & we_i & sel_i[0] & (adr_i == tmx_pkg::OFS_MODE);
        wr_pre = acc & we_i & sel_i[0] & (adr_i == tmx_pkg::OFS_PRE);
        wr_cnt = acc & we_i & sel_i[0] & (adr_i == tmx_pkg::OFS_CNT);
        wr_src = acc & we_i & sel_i[0] & (adr_i == tmx_pkg::OFS_SRC);
        wr_msk = acc & we_i & sel_i[0] & (adr_i == tmx_pkg::OFS_IMSK);
        rd_ist = acc & ~we_i & (adr_i == tmx_pkg::OFS_IST);
        ppm = (mode_r == tmx_pkg::TMX_MODE_MEAS) & extra_r;
        // Event counter mode counts pin edges instead of source ticks
        tick_c = (mode_r == tmx_pkg::TMX_MODE_EVENT) ? edge_evt : src_tick;
        // Only an already-running tick counts; stop tick does not count
        count_en = tick_c & (run_r == tmx_pkg::TMX_RUNNING) & cmd_r;
        pre_uf = count_en & (pre_cnt_r == '0);
        uf_evt = pre_uf & (cnt_r == '0);
        edge_set = ppm & pre_uf & (pend_r | edge_evt);
    end

    // Mode register and run state next values
    always_comb begin
        mode_nxt = mode_r;
        extra_nxt = extra_r;
        pol_nxt = pol_r;
        cmd_nxt = cmd_r;
        run_nxt = run_r;
        edge_flag_nxt = edge_flag_r;
        uf_flag_nxt = uf_flag_r;
        if (wr_mode) begin
            // Mode and run bits accepted as written by software
            mode_nxt = tmx_pkg::tmx_mode_t'(wdb[tmx_pkg::BIT_SEL_HI:tmx_pkg::BIT_SEL_LO]);
            extra_nxt = wdb[tmx_pkg::BIT_EXTRA];
            pol_nxt = wdb[tmx_pkg::BIT_POL];
            cmd_nxt = wdb[tmx_pkg::BIT_RUN];
            // Flags are clear-only by software, and only when measuring
            if (ppm && !wdb[tmx_pkg::BIT_EDGE]) begin
                edge_flag_nxt = 1'b0;
            end
            if (ppm && !wdb[tmx_pkg::BIT_UF]) begin
                uf_flag_nxt = 1'b0;
            end
        end
        // Hardware set wins over a same-cycle clear
        if (edge_set) begin
            edge_flag_nxt = 1'b1;
        end
        if (uf_evt) begin
            uf_flag_nxt = 1'b1;
        end
        // Run flop follows the command latch on every tick only
        if (tick_c) begin
            run_nxt = cmd_r ? tmx_pkg::TMX_RUNNING : tmx_pkg::TMX_STOPPED;
        end
    end

    // Prescaler, counter, capture and pulse next values
    always_comb begin
        pre_rld_nxt = pre_rld_r;
        pre_cnt_nxt = pre_cnt_r;
        cnt_rld_nxt = cnt_rld_r;
        cnt_nxt = cnt_r;
        cap_nxt = cap_r;
        pend_nxt = pend_r;
        pulse_nxt = pulse_r;
        src_nxt = src_r;
        // Halted counters hold; the tick gates every decrement
        if (count_en) begin
            pre_cnt_nxt = pre_uf ? pre_rld_r : pre_cnt_r - CNT_W'(1);
        end
        if (pre_uf) begin
            cnt_nxt = uf_evt ? cnt_rld_r : cnt_r - CNT_W'(1);
        end
        // Measured edge is resolved at the next prescaler underflow
        if (ppm && edge_evt) begin
            pend_nxt = 1'b1;
        end
        if (edge_set) begin
            cap_nxt = cnt_r;
            cnt_nxt = cnt_rld_r;
            pend_nxt = 1'b0;
        end
        if (!ppm) begin
            pend_nxt = 1'b0;
        end
        if (uf_evt && mode_r == tmx_pkg::TMX_MODE_PULSE) begin
            pulse_nxt = ~pulse_r;
        end
        // Software loads win over counting in the same cycle
        if (wr_pre) begin
            pre_rld_nxt = wdb[CNT_W-1:0];
            pre_cnt_nxt = wdb[CNT_W-1:0];
        end
        if (wr_cnt) begin
            cnt_rld_nxt = wdb[CNT_W-1:0];
            cnt_nxt = wdb[CNT_W-1:0];
        end
        if (wr_src) begin
            src_nxt = wdb[1:0];
        end
    end

    // Events into sticky status, one per bit
    assign ev[tmx_pkg::IRQ_UF] = uf_evt;
    assign ev[tmx_pkg::IRQ_EDGE] = edge_set;
    for (genvar i = 0; i < tmx_pkg::IRQ_N; i++) begin : g_ist
        // Read clears, but an event in the same cycle survives
        assign ist_nxt[i] = ev[i] | (ist_r[i] & ~rd_ist);
    end

    // Mask and bus slave next values
    always_comb begin
        imsk_nxt = imsk_r;
        if (wr_msk) begin
            imsk_nxt = wdb[tmx_pkg::IRQ_N-1:0];
        end
        // Live values; every register reads as one byte, nothing is latched
        case (adr_i)
            tmx_pkg::OFS_MODE: rmux = {1'b0, uf_flag_r, edge_flag_r, pol_r,
                run_r, extra_r, mode_r};
            tmx_pkg::OFS_PRE: rmux = 8'(pre_cnt_r);
            tmx_pkg::OFS_CNT: rmux = 8'(cnt_r);
            tmx_pkg::OFS_SRC: rmux = {6'h00, src_r};
            tmx_pkg::OFS_IST: rmux = 8'(ist_r);
            tmx_pkg::OFS_IMSK: rmux = 8'(imsk_r);
            tmx_pkg::OFS_CAP: rmux = 8'(cap_r);
            default: rmux = 8'h00;
        endcase
        // Ack one cycle after request, unmapped answers zero
        ack_nxt = cyc_i & stb_i & ~ack_r;
        rdat_nxt = ack_nxt ? {24'h000000, rmux} : rdat_r;
    end

    // Registers only
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            mode_r <= tmx_pkg::TMX_MODE_TIMER;
            extra_r <= 1'b0;
            pol_r <= 1'b0;
            cmd_r <= 1'b0;
            run_r <= tmx_pkg::TMX_STOPPED;
            edge_flag_r <= 1'b0;
            uf_flag_r <= 1'b0;
            pre_rld_r <= CNT_W'(tmx_pkg::RST_PRE);
            pre_cnt_r <= CNT_W'(tmx_pkg::RST_PRE);
            cnt_rld_r <= CNT_W'(tmx_pkg::RST_CNT);
            cnt_r <= CNT_W'(tmx_pkg::RST_CNT);
            cap_r <= '0;
            pend_r <= 1'b0;
            pulse_r <= 1'b0;
            src_r <= tmx_pkg::RST_SRC;
            ist_r <= '0;
            imsk_r <= '0;
            ack_r <= 1'b0;
            rdat_r <= 32'h00000000;
        end else begin
            mode_r <= mode_nxt;
            extra_r <= extra_nxt;
            pol_r <= pol_nxt;
            cmd_r <= cmd_nxt;
            run_r <= run_nxt;
            edge_flag_r <= edge_flag_nxt;
            uf_flag_r <= uf_flag_nxt;
            pre_rld_r <= pre_rld_nxt;
            pre_cnt_r <= pre_cnt_nxt;
            cnt_rld_r <= cnt_rld_nxt;
            cnt_r <= cnt_nxt;
            cap_r <= cap_nxt;
            pend_r <= pend_nxt;
            pulse_r <= pulse_nxt;
            src_r <= src_nxt;
            ist_r <= ist_nxt;
            imsk_r <= imsk_nxt;
            ack_r <= ack_nxt;
            rdat_r <= rdat_nxt;
        end
    end

    assign ack_o = ack_r;
    assign dat_o = rdat_r;
    assign pulse_o = pulse_r;
    assign run_o = run_r;
    assign irq_o = |(ist_r & imsk_r);

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    reset_halted_a: assert property ($fell(rst_i) |-> run_r == tmx_pkg::TMX_STOPPED && !cmd_r)
        else $error("timer not halted after reset");
    start_wait_a: assert property (cmd_r && run_r == tmx_pkg::TMX_STOPPED && !tick_c
        |=> run_r == tmx_pkg::TMX_STOPPED)
        else $error("run bit rose without a tick");
    start_tick_a: assert property (tick_c && cmd_r |=> run_r == tmx_pkg::TMX_RUNNING)
        else $error("run bit missed the start tick");
    stopped_hold_a: assert property (run_r == tmx_pkg::TMX_STOPPED && !wr_pre
        |=> pre_cnt_r == $past(pre_cnt_r))
        else $error("prescaler moved while stopped");
    stop_tick_a: assert property (tick_c && !cmd_r |=> run_r == tmx_pkg::TMX_STOPPED)
        else $error("counter did not halt at tick");
    stop_pending_a: assert property (run_r == tmx_pkg::TMX_RUNNING && !cmd_r && !tick_c
        |=> run_r == tmx_pkg::TMX_RUNNING)
        else $error("run bit fell before halt tick");
    flag_keep_a: assert property (wr_mode && ppm && wdb[tmx_pkg::BIT_UF] && uf_flag_r
        |=> uf_flag_r)
        else $error("writing 1 altered underflow flag");
    flag_clear_a: assert property (wr_mode && ppm && !wdb[tmx_pkg::BIT_EDGE] && !edge_set
        |=> !edge_flag_r)
        else $error("writing 0 did not clear edge flag");
    edge_source_a: assert property ($rose(edge_flag_r) |-> $past(pre_uf))
        else $error("edge flag set without prescaler underflow");
    read_live_a: assert property (cyc_i && stb_i && !we_i && !ack_r
        && adr_i == tmx_pkg::OFS_CNT |=> ack_o && dat_o[7:0] == 8'($past(cnt_r)))
        else $error("counter read not live");
    ack_single_a: assert property (ack_o |=> !ack_o)
        else $error("ack held longer than one cycle");
endmodule
`default_nettype wire

// *** tmx_pkg.sv ***
`default_nettype none
// Shared map, field layout and encodings of the 8-bit prescaler timer
package tmx_pkg;
    // Word-aligned byte offsets on the register bus
    localparam logic [7:0] OFS_MODE = 8'h00;
    localparam logic [7:0] OFS_PRE = 8'h04;
    localparam logic [7:0] OFS_CNT = 8'h08;
    localparam logic [7:0] OFS_SRC = 8'h0C;
    localparam logic [7:0] OFS_IST = 8'h10;
    localparam logic [7:0] OFS_IMSK = 8'h14;
    localparam logic [7:0] OFS_CAP = 8'h18;
    // Bit positions inside the mode register
    localparam int BIT_SEL_LO = 0;
    localparam int BIT_SEL_HI = 1;
    localparam int BIT_EXTRA = 2;
    localparam int BIT_RUN = 3;
    localparam int BIT_POL = 4;
    localparam int BIT_EDGE = 5;
    localparam int BIT_UF = 6;
    // Interrupt status and mask bit positions
    localparam int IRQ_UF = 0;
    localparam int IRQ_EDGE = 1;
    localparam int IRQ_N = 2;
    // Reset values of the reload, count and source select registers
    localparam logic [7:0] RST_PRE = 8'hFF;
    localparam logic [7:0] RST_CNT = 8'hFF;
    localparam logic [1:0] RST_SRC = 2'h0;
    // Divider exponent step per count source select code
    localparam int SRC_SHIFT_STEP = 2;
    // Operating mode select codes
    typedef enum logic [1:0] {
        TMX_MODE_TIMER = 2'b00,
        TMX_MODE_PULSE = 2'b01,
        TMX_MODE_EVENT = 2'b10,
        TMX_MODE_MEAS = 2'b11
    } tmx_mode_t;
    // Running state seen on the run bit
    typedef enum logic {
        TMX_STOPPED = 1'b0,
        TMX_RUNNING = 1'b1
    } tmx_run_t;
endpackage
`default_nettype wire

// *** tmx_src_tick.sv ***
`default_nettype none
// Count source: one-cycle tick every 4^sel clocks
module tmx_src_tick #(
    parameter int DIV_W = 6
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [1:0] sel_i,
    output logic tick_o
);
    // Divider must hold the longest ratio
    if (DIV_W < 3 * tmx_pkg::SRC_SHIFT_STEP) begin : g_chk
        $error("tmx_src_tick: DIV_W too small");
    end

    logic [DIV_W-1:0] div_r; // Free-running divider
    logic [DIV_W-1:0] div_nxt;
    logic tick_r; // Registered tick
    logic tick_nxt;
    logic [DIV_W-1:0] mask; // Low bits that must be all ones

    // Divider next state; ratio changes act at once, may give one short period
    always_comb begin
        mask = DIV_W'((1 << (tmx_pkg::SRC_SHIFT_STEP * int'(sel_i))) - 1);
        div_nxt = div_r + DIV_W'(1);
        tick_nxt = ((div_r & mask) == mask);
    end

    // Registers only
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            div_r <= '0;
            tick_r <= 1'b0;
        end else begin
            div_r <= div_nxt;
            tick_r <= tick_nxt;
        end
    end

    assign tick_o = tick_r;
endmodule
`default_nettype wire

// *** tmx_edge_det.sv ***
`default_nettype none
// Edge detector on the measurement pin, polarity selectable
module tmx_edge_det (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic sig_i,
    input wire logic pol_i,
    output logic edge_o
);
    logic prev_r; // Last sampled level
    logic edge_r; // Registered edge pulse
    logic edge_nxt;

    // Rising edge when pol is 0, falling edge when pol is 1
    always_comb begin
        edge_nxt = pol_i ? (prev_r & ~sig_i) : (~prev_r & sig_i);
    end

    // Registers only
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            prev_r <= 1'b0;
            edge_r <= 1'b0;
        end else begin
            prev_r <= sig_i;
            edge_r <= edge_nxt;
        end
    end

    assign edge_o = edge_r;

    // Same-direction edges need a level change in between
    edge_single_a: assert property (@(posedge clk_i) disable iff (rst_i)
        edge_o |=> !edge_o)
        else $error("edge pulse longer than one cycle");
endmodule
`default_nettype wire

// *** tb_top.sv ***
`default_nettype none
// One comparison with count and report; four-state equality so X never matches
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin miscompares++; \
    $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (g), (e)); end end
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_i = 1'b0; // Bus clock, 25 MHz
    logic rst_i = 1'b1; // Synchronous reset, active high
    logic cyc_i = 1'b0;
    logic stb_i = 1'b0;
    logic we_i = 1'b0;
    logic meas_i = 1'b0; // Measurement pin
    logic [7:0] adr_i = 8'h00;
    logic [3:0] sel_i = 4'h0;
    logic [31:0] dat_i = 32'h0;
    logic [31:0] dat_o;
    logic [31:0] q; // Last read data
    logic [31:0] p0; // Earlier sample of a live count
    logic ack_o, pulse_o, run_o, irq_o;
    logic [7:0] pv, cv; // Random load values
    int miscompares = 0;
    int cmp_count = 0;
    int cycles = 0;
    int mdl[7]; // Readback model, one entry per register word
    // Clock generator
    always #20 clk_i = ~clk_i;
    tmx_timer #(.CNT_W(8), .DIV_W(6)) uut (
        .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
        .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
        .meas_i(meas_i), .pulse_o(pulse_o), .run_o(run_o), .irq_o(irq_o)
    );
    // Verdict and end of run, the only exit
    task automatic conclude;
        $display("miscompares=%0d cmp_count=%0d", miscompares, cmp_count);
        if (miscompares == 0 && cmp_count > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    // Hang guard: far above the fewer than one thousand cycles the sequence needs
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 20000) begin
            miscompares++;
            conclude();
        end
    end
    // Classic single Wishbone cycle; request held until ack is sampled high
    task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d);
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i <= w;
        adr_i <= a;
        sel_i <= 4'h1;
        dat_i <= {24'h0, d};
        @(posedge clk_i);
        // No wait-state count assumed; the hang guard ends a dead bus
        while (ack_o !== 1'b1) begin
            @(posedge clk_i);
        end
        q = dat_o;
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
        we_i <= 1'b0;
        // Idle cycle between requests
        @(posedge clk_i);
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        wb(1'b1, a, d);
        if (a <= tmx_pkg::OFS_CAP && a[1:0] == 2'b00 && a != tmx_pkg::OFS_MODE) begin
            mdl[a[7:2]] = int'(d);
        end
    endtask
    task automatic rd(input logic [7:0] a);
        wb(1'b0, a, 8'h00);
    endtask
    // Bounded wait for the running state to reach a level
    task automatic wait_run(input logic v);
        int n;
        n = 0;
        while (run_o !== v && n < 500) begin
            @(posedge clk_i);
            n++;
        end
        if (n == 500) begin
            miscompares++;
            conclude();
        end
    endtask
    initial begin
        void'($urandom(32'h44bcf564));
        mdl = '{0, 'hFF, 'hFF, 0, 0, 0, 0};
        pv = 8'($urandom_range(8'hFE, 8'h10));
        cv = 8'($urandom_range(8'hFE, 8'h10));
        repeat (5) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        `CHK(run_o, 1'b0)
        `CHK(pulse_o, 1'b0)
        `CHK(irq_o, 1'b0)
        // Reset values, unmapped and misaligned places read zero
        wr(8'h1C, 8'h5A);
        for (int i = 0; i < 7; i++) begin
            rd(8'(i * 4));
            `CHK(q, 32'(mdl[i]))
        end
        rd(8'h1C);
        `CHK(q, 32'h0)
        rd(8'h02);
        `CHK(q, 32'h0)
        // Load before starting; slowest source so tick phase is easy to hold
        wr(tmx_pkg::OFS_PRE, pv);
        wr(tmx_pkg::OFS_CNT, cv);
        wr(tmx_pkg::OFS_SRC, 8'h03);
        for (int i = 1; i < 4; i++) begin
            rd(8'(i * 4));
            `CHK(q, 32'(mdl[i]))
        end
        // Start, then stop straight after the start tick
        wr(tmx_pkg::OFS_MODE, 8'h08);
        wait_run(1'b1);
        rd(tmx_pkg::OFS_PRE);
        `CHK(q, {24'h0, pv})
        rd(tmx_pkg::OFS_MODE);
        `CHK(q, 32'h08)
        wr(tmx_pkg::OFS_MODE, 8'h00);
        rd(tmx_pkg::OFS_MODE);
        `CHK(q, 32'h08)
        wait_run(1'b0);
        rd(tmx_pkg::OFS_MODE);
        `CHK(q, 32'h00)
        rd(tmx_pkg::OFS_PRE);
        `CHK(q, {24'h0, pv})
        // Restart right after a tick: bit must still read 0
        wr(tmx_pkg::OFS_MODE, 8'h08);
        rd(tmx_pkg::OFS_MODE);
        `CHK(q, 32'h00)
        wait_run(1'b1);
        repeat (64 * 3 + 32) @(posedge clk_i);
        rd(tmx_pkg::OFS_PRE);
        `CHK(q, {24'h0, pv - 8'h03})
        // Fast source: two reads of a live count are not latched
        wr(tmx_pkg::OFS_SRC, 8'h00);
        rd(tmx_pkg::OFS_PRE);
        p0 = q;
        rd(tmx_pkg::OFS_PRE);
        `CHK(q != p0, 1'b1)
        wr(tmx_pkg::OFS_MODE, 8'h00);
        wait_run(1'b0);
        // Measurement mode: clear flags, start, feed one edge, stop keeping flags
        wr(tmx_pkg::OFS_PRE, 8'h00);
        wr(tmx_pkg::OFS_CNT, 8'h03);
        // Mode select first, then the extra bit, never together
        wr(tmx_pkg::OFS_MODE, 8'h03);
        wr(tmx_pkg::OFS_MODE, 8'h07);
        // Now measuring: zeros clear both flags before the start
        wr(tmx_pkg::OFS_MODE, 8'h07);
        rd(tmx_pkg::OFS_MODE);
        `CHK(q, 32'h07)
        wr(tmx_pkg::OFS_IMSK, 8'h03);
        wr(tmx_pkg::OFS_MODE, 8'h6F);
        wait_run(1'b1);
        repeat (20) @(posedge clk_i);
        meas_i <= 1'b1;
        repeat (40) @(posedge clk_i);
        wr(tmx_pkg::OFS_MODE, 8'h67);
        wait_run(1'b0);
        rd(tmx_pkg::OFS_MODE);
        `CHK(q, 32'h67)
        `CHK(irq_o, 1'b1)
        // Capture holds a counter value inside the reload range
        rd(tmx_pkg::OFS_CAP);
        `CHK(q <= 32'h03, 1'b1)
        // Well past two prescaler periods, so clearing is safe
        wr(tmx_pkg::OFS_MODE, 8'h47);
        rd(tmx_pkg::OFS_MODE);
        `CHK(q, 32'h47)
        wr(tmx_pkg::OFS_MODE, 8'h07);
        rd(tmx_pkg::OFS_MODE);
        `CHK(q, 32'h07)
        // Interrupt masking and clear on status read
        wr(tmx_pkg::OFS_IMSK, 8'h00);
        `CHK(irq_o, 1'b0)
        wr(tmx_pkg::OFS_IMSK, 8'h03);
        `CHK(irq_o, 1'b1)
        rd(tmx_pkg::OFS_IST);
        `CHK(q, 32'h03)
        `CHK(irq_o, 1'b0)
        rd(tmx_pkg::OFS_IST);
        `CHK(q, 32'h00)
        // Pulse output: extra bit off first, then mode, then start
        wr(tmx_pkg::OFS_MODE, 8'h03);
        wr(tmx_pkg::OFS_MODE, 8'h01);
        wr(tmx_pkg::OFS_MODE, 8'h09);
        wait_run(1'b1);
        // Reloads 0 and 3: exactly one toggle in any four counting ticks
        p0 = {31'h0, pulse_o};
        repeat (4) @(posedge clk_i);
        `CHK(pulse_o, ~p0[0])
        repeat (4) @(posedge clk_i);
        `CHK(pulse_o, p0[0])
        wr(tmx_pkg::OFS_MODE, 8'h01);
        wait_run(1'b0);
        // Event count: each rising pin edge is a tick, the first only starts
        wr(tmx_pkg::OFS_MODE, 8'h02);
        wr(tmx_pkg::OFS_CNT, 8'h05);
        wr(tmx_pkg::OFS_MODE, 8'h0A);
        for (int i = 0; i < 4; i++) begin
            meas_i <= 1'b0;
            repeat (2) @(posedge clk_i);
            meas_i <= 1'b1;
            repeat (2) @(posedge clk_i);
        end
        wait_run(1'b1);
        rd(tmx_pkg::OFS_CNT);
        `CHK(q, 32'h02)
        conclude();
    end
endmodule
`default_nettype wire
